// ### core/dacl_pkg.sv
/*
  package for the double-buffered converter latch controller: pin enable codes,
  write modes, sequencer states and bus-cycle timing counts.
  assumes a single 25 MHz clock; all times below are in nanoseconds.
*/
package dacl_pkg;

  // clock period in ns
  localparam int CLK_PERIOD_NS = 40;

  // write-cycle timing; plain defaults, adjust to the part's timing sheet
  localparam int SETUP_NS = 40;   // address/data stable before select falls
  localparam int STROBE_NS = 100; // select low width
  localparam int HOLD_NS = 40;    // address/data held after select rises

  // least times round up, never below one cycle
  function automatic logic [7:0] ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction

  localparam logic [7:0] SETUP_CYC = ns_to_cycles(SETUP_NS);
  localparam logic [7:0] STROBE_CYC = ns_to_cycles(STROBE_NS);
  localparam logic [7:0] HOLD_CYC = ns_to_cycles(HOLD_NS);

  // data width and field positions of the code pins
  localparam int CODE_W = 12;
  localparam int TOP_BIT = 11;

  // enable mask bit positions (active high inside the controller)
  localparam int EN_LOW = 0;
  localparam int EN_MID = 1;
  localparam int EN_HIGH = 2;
  localparam int EN_XFER = 3;

  // enable masks per write step
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_LOW = 4'h1;
  localparam logic [3:0] MASK_MID = 4'h2;
  localparam logic [3:0] MASK_HIGH = 4'h4;
  localparam logic [3:0] MASK_XFER = 4'h8;
  localparam logic [3:0] MASK_LOW_MID = 4'h3;
  localparam logic [3:0] MASK_FIRST = 4'h7;
  localparam logic [3:0] MASK_MID_HI_X = 4'hE;
  localparam logic [3:0] MASK_HI_X = 4'hC;
  localparam logic [3:0] MASK_ALL = 4'hF;

  // bus hookup being emulated
  typedef enum logic [1:0] {
    DACL_MODE_WIDE = 2'h0,   // 12/16-bit bus, one address
    DACL_MODE_LEFT8 = 2'h1,  // 8-bit bus, left-justified
    DACL_MODE_RIGHT8 = 2'h2, // 8-bit bus, right-justified
    DACL_MODE_NIBBLE = 2'h3  // 4-bit bus, three nibbles then transfer
  } dacl_mode_t;

  // sequencer states, gray along idle-setup-strobe-hold
  typedef enum logic [1:0] {
    DACL_IDLE = 2'h0,
    DACL_SETUP = 2'h1,
    DACL_STROBE = 2'h3,
    DACL_HOLD = 2'h2
  } dacl_state_t;

endpackage

// ### core/dacl_timer.sv
/*
  down-counter that times each phase of a latch write cycle.
  assumes the loader gives a count of at least one; o_expired rises after
  that many cycles in the phase, counting the load cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module dacl_timer
  import dacl_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // load
  input wire logic i_load,
  input wire logic [7:0] i_count,
  // status
  output logic o_expired
);

  logic [7:0] count;
  logic [7:0] next_count;

  // load count-1 so a phase lasts exactly i_count cycles
  always_comb begin
    next_count = count;
    if (i_load) begin
      next_count = (i_count == 8'h00) ? 8'h00 : i_count - 8'h01;
    end else if (count != 8'h00) begin
      next_count = count - 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count <= 8'h00;
    end else begin
      count <= next_count;
    end
  end

  // plain decode of the count: the sequencer reloads on expiry in the same
  // cycle, so gating with i_load here would close a combinational loop
  assign o_expired = (count == 8'h00);

endmodule
`default_nettype wire

// ### core/dacl_ctrl.sv
/*
  host controller that drives the pins of a double-buffered 12-bit converter
  latch: active-low select, four active-low latch enables and 12 code pins.
  assumes the converter's latches are level-sensitive and pins are wired
  straight across; one user request writes one 12-bit code.
*/
`timescale 1ns/1ps
`default_nettype none
module dacl_ctrl
  import dacl_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // user request
  input wire logic i_req,
  input wire logic [11:0] i_code,
  input wire logic [1:0] i_mode,
  input wire logic i_twos,
  input wire logic i_double,
  // user status
  output logic o_busy,
  output logic o_done,
  // converter pins
  output logic o_select_n,
  output logic o_low_nibble_enable_n,
  output logic o_mid_nibble_enable_n,
  output logic o_high_nibble_enable_n,
  output logic o_transfer_enable_n,
  output logic [11:0] o_code_in
);

  // enable mask for write step idx of a mode; MASK_NONE ends the sequence
  // three nibble latches of the first rank, with the second rank opened in the last step
  function automatic logic [3:0] step_mask(input logic [1:0] mode, input logic dbl, input logic [1:0] idx);
    logic [3:0] m;
    m = MASK_NONE;
    case (mode)
      DACL_MODE_WIDE: begin
        if (dbl) begin
          // first rank, then a separate transfer keeps the output glitch-free
          m = (idx == 2'h0) ? MASK_FIRST : ((idx == 2'h1) ? MASK_XFER : MASK_NONE);
        end else begin
          m = (idx == 2'h0) ? MASK_ALL : MASK_NONE;
        end
      end
      DACL_MODE_LEFT8: begin
        m = (idx == 2'h0) ? MASK_LOW : ((idx == 2'h1) ? MASK_MID_HI_X : MASK_NONE);
      end
      DACL_MODE_RIGHT8: begin
        m = (idx == 2'h0) ? MASK_LOW_MID : ((idx == 2'h1) ? MASK_HI_X : MASK_NONE);
      end
      DACL_MODE_NIBBLE: begin
        case (idx)
          2'h0: m = MASK_LOW;
          2'h1: m = MASK_MID;
          2'h2: m = MASK_HIGH;
          default: m = MASK_XFER;
        endcase
      end
      default: m = MASK_NONE;
    endcase
    return m;
  endfunction

  // bytes of an 8-bit bus: only the lanes of the current byte carry code bits
  function automatic logic [11:0] lane_data(input logic [1:0] mode, input logic [11:0] code, input logic [3:0] mask);
    logic [11:0] d;
    d = code;
    if (mode == DACL_MODE_LEFT8 || mode == DACL_MODE_RIGHT8) begin
      d = 12'h000;
      if (mask[EN_LOW]) begin
        d[3:0] = code[3:0];
      end
      if (mask[EN_MID]) begin
        d[7:4] = code[7:4];
      end
      if (mask[EN_HIGH]) begin
        d[11:8] = code[11:8];
      end
    end
    return d;
  endfunction

  dacl_state_t state;
  dacl_state_t next_state;
  logic [1:0] step;
  logic [1:0] next_step;
  logic [11:0] code;
  logic [11:0] next_code;
  logic [1:0] mode;
  logic [1:0] next_mode;
  logic dbl;
  logic next_dbl;
  logic [3:0] en;
  logic [3:0] next_en;
  logic sel;
  logic next_sel;
  logic [11:0] pins;
  logic [11:0] next_pins;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;
  logic pin_sel_n;
  logic next_pin_sel_n;
  logic [3:0] pin_en_n;
  logic [3:0] next_pin_en_n;
  logic tmr_load;
  logic [7:0] tmr_count;
  logic tmr_expired;
  logic [3:0] mask_next;

  dacl_timer u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_expired(tmr_expired)
  );

  assign mask_next = step_mask(mode, dbl, step + 2'h1);

  // sequencer: enables and data change only while select is high, so no
  // latch sees a half-changed address; select low opens the chosen latches
  always_comb begin
    next_state = state;
    next_step = step;
    next_code = code;
    next_mode = mode;
    next_dbl = dbl;
    next_en = en;
    next_sel = sel;
    next_pins = pins;
    next_busy = busy;
    next_done = 1'b0;
    tmr_load = 1'b0;
    tmr_count = SETUP_CYC;
    case (state)
      DACL_IDLE: begin
        if (i_req) begin
          // two's complement callers get the top bit flipped to offset binary
          next_code = {i_code[TOP_BIT] ^ i_twos, i_code[TOP_BIT-1:0]};
          next_mode = i_mode;
          next_dbl = i_double;
          next_step = 2'h0;
          next_en = step_mask(i_mode, i_double, 2'h0);
          next_pins = lane_data(i_mode, next_code, next_en);
          next_busy = 1'b1;
          tmr_load = 1'b1;
          tmr_count = SETUP_CYC;
          next_state = DACL_SETUP;
        end
      end
      DACL_SETUP: begin
        if (tmr_expired) begin
          next_sel = 1'b1;
          tmr_load = 1'b1;
          tmr_count = STROBE_CYC;
          next_state = DACL_STROBE;
        end
      end
      DACL_STROBE: begin
        if (tmr_expired) begin
          // rising select closes the open latches on the held data
          next_sel = 1'b0;
          tmr_load = 1'b1;
          tmr_count = HOLD_CYC;
          next_state = DACL_HOLD;
        end
      end
      DACL_HOLD: begin
        if (tmr_expired) begin
          if (step != 2'h3 && mask_next != MASK_NONE) begin
            // next nibble or the transfer step, sequenced low to high
            next_step = step + 2'h1;
            next_en = mask_next;
            next_pins = lane_data(mode, code, mask_next);
            tmr_load = 1'b1;
            tmr_count = SETUP_CYC;
            next_state = DACL_SETUP;
          end else begin
            // park with every enable released and data low, like grounded pins
            next_en = MASK_NONE;
            next_pins = 12'h000;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = DACL_IDLE;
          end
        end
      end
      default: begin
        next_sel = 1'b0;
        next_en = MASK_NONE;
        next_busy = 1'b0;
        next_state = DACL_IDLE;
      end
    endcase
    // active-low pin images, registered so every pin leaves a flop
    next_pin_sel_n = ~next_sel;
    next_pin_en_n = ~next_en;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= DACL_IDLE;
      step <= 2'h0;
      code <= 12'h000;
      mode <= DACL_MODE_WIDE;
      dbl <= 1'b0;
      en <= MASK_NONE;
      sel <= 1'b0;
      pins <= 12'h000;
      busy <= 1'b0;
      done <= 1'b0;
      pin_sel_n <= 1'b1;
      pin_en_n <= 4'hF;
    end else begin
      state <= next_state;
      step <= next_step;
      code <= next_code;
      mode <= next_mode;
      dbl <= next_dbl;
      en <= next_en;
      sel <= next_sel;
      pins <= next_pins;
      busy <= next_busy;
      done <= next_done;
      pin_sel_n <= next_pin_sel_n;
      pin_en_n <= next_pin_en_n;
    end
  end

  // pins come straight from flops; held data stays on the pins
  // under select, since any change there would leak to the output
  assign o_select_n = pin_sel_n;
  assign o_low_nibble_enable_n = pin_en_n[EN_LOW];
  assign o_mid_nibble_enable_n = pin_en_n[EN_MID];
  assign o_high_nibble_enable_n = pin_en_n[EN_HIGH];
  assign o_transfer_enable_n = pin_en_n[EN_XFER];
  assign o_code_in = pins;
  assign o_busy = busy;
  assign o_done = done;

endmodule
`default_nettype wire

// ### verif/dacl_asserts.sv
/* pin and status checks for dacl_ctrl.
   assumes one clock domain; bound to every dacl_ctrl instance. */
`timescale 1ns/1ps
`default_nettype none
module dacl_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // user side
  input wire logic i_req,
  input wire logic [11:0] i_code,
  input wire logic [1:0] i_mode,
  input wire logic i_twos,
  input wire logic i_double,
  input wire logic o_busy,
  input wire logic o_done,
  // converter pins
  input wire logic o_select_n,
  input wire logic o_low_nibble_enable_n,
  input wire logic o_mid_nibble_enable_n,
  input wire logic o_high_nibble_enable_n,
  input wire logic o_transfer_enable_n,
  input wire logic [11:0] o_code_in
);
  logic [3:0] en_n;
  logic take;
  // enables packed transfer, high, mid, low
  assign en_n = {o_transfer_enable_n, o_high_nibble_enable_n, o_mid_nibble_enable_n, o_low_nibble_enable_n};
  assign take = i_req && !o_busy;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // a moving pin under select would smear data into an open latch
  property p_hold; !o_select_n && $past(!o_select_n) |-> $stable(en_n) && $stable(o_code_in); endproperty
  a_hold: assert property (p_hold) else $error("pins moved under select");
  property p_strobe; $fell(o_select_n) |-> !o_select_n [*3] ##1 o_select_n; endproperty
  a_strobe: assert property (p_strobe) else $error("select width wrong");
  property p_setup; $fell(o_select_n) |-> $stable(en_n) && $stable(o_code_in) && en_n != 4'hF; endproperty
  a_setup: assert property (p_setup) else $error("select fell without setup");
  property p_idle; !o_busy |-> o_select_n && en_n == 4'hF && o_code_in == 12'h000; endproperty
  a_idle: assert property (p_idle) else $error("pins active while idle");
  property p_wide; take && i_mode == 2'h0 && !i_double |=> en_n == 4'h0 &&
    o_code_in == ($past(i_code) ^ {$past(i_twos), 11'h000}); endproperty
  a_wide: assert property (p_wide) else $error("wide step pins wrong");
  property p_left; take && i_mode == 2'h1 |=> en_n == 4'hE && o_code_in == {8'h00, $past(i_code[3:0])}; endproperty
  a_left: assert property (p_left) else $error("left first byte wrong");
  property p_right; take && i_mode == 2'h2 |=> en_n == 4'hC && o_code_in == {4'h0, $past(i_code[7:0])}; endproperty
  a_right: assert property (p_right) else $error("right first byte wrong");
  property p_wdone; take && i_mode == 2'h0 && !i_double |-> ##6 o_done; endproperty
  a_wdone: assert property (p_wdone) else $error("wide write late");
  property p_ndone; take && i_mode == 2'h3 |-> ##21 o_done; endproperty
  a_ndone: assert property (p_ndone) else $error("nibble write late");
endmodule
bind dacl_ctrl dacl_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_code(i_code),
  .i_mode(i_mode), .i_twos(i_twos), .i_double(i_double), .o_busy(o_busy), .o_done(o_done),
  .o_select_n(o_select_n), .o_low_nibble_enable_n(o_low_nibble_enable_n),
  .o_mid_nibble_enable_n(o_mid_nibble_enable_n), .o_high_nibble_enable_n(o_high_nibble_enable_n),
  .o_transfer_enable_n(o_transfer_enable_n), .o_code_in(o_code_in));
`default_nettype wire

// ### verif/dacl_dev_model.sv
/* behavioural two-rank input latch of the converter.
   assumes pins wired straight from the controller; no clock. */
`timescale 1ns/1ps
`default_nettype none
module dacl_dev_model (
  // pins
  input wire logic i_select_n,
  input wire logic i_low_nibble_enable_n,
  input wire logic i_mid_nibble_enable_n,
  input wire logic i_high_nibble_enable_n,
  input wire logic i_transfer_enable_n,
  input wire logic [11:0] i_code_in,
  // latch contents
  output logic [3:0] o_low_nibble_latch,
  output logic [3:0] o_middle_nibble_latch,
  output logic [3:0] o_high_nibble_latch,
  output logic [11:0] o_output_code_latch
);
  // first rank: each enable opens one nibble while select is low, holds otherwise
  always_latch begin
    if (!i_select_n && !i_low_nibble_enable_n) begin
      o_low_nibble_latch <= i_code_in[3:0];
    end
    if (!i_select_n && !i_mid_nibble_enable_n) begin
      o_middle_nibble_latch <= i_code_in[7:4];
    end
    if (!i_select_n && !i_high_nibble_enable_n) begin
      o_high_nibble_latch <= i_code_in[11:8];
    end
  end
  // second rank alone feeds the core; transparent through an open first rank
  always_latch begin
    if (!i_select_n && !i_transfer_enable_n) begin
      o_output_code_latch <= {o_high_nibble_latch, o_middle_nibble_latch, o_low_nibble_latch};
    end
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
/* self-checking bench for dacl_ctrl driving the latch model.
   assumes the model sits straight on the converter pins. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk, i_rst, i_req, i_twos, i_double, o_busy, o_done;
  logic sel_n, en_lo, en_mi, en_hi, en_xf;
  logic [1:0] i_mode;
  logic [11:0] i_code, pins, out;
  logic [3:0] lo, mi, hi;
  logic [11:0] codes [4] = '{12'h000, 12'hFFF, 12'h800, 12'h5A3};
  int n_errors, n_checks;
  dacl_ctrl i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_code(i_code), .i_mode(i_mode),
    .i_twos(i_twos), .i_double(i_double), .o_busy(o_busy), .o_done(o_done), .o_select_n(sel_n),
    .o_low_nibble_enable_n(en_lo), .o_mid_nibble_enable_n(en_mi), .o_high_nibble_enable_n(en_hi),
    .o_transfer_enable_n(en_xf), .o_code_in(pins));
  dacl_dev_model i_dev (.i_select_n(sel_n), .i_low_nibble_enable_n(en_lo), .i_mid_nibble_enable_n(en_mi),
    .i_high_nibble_enable_n(en_hi), .i_transfer_enable_n(en_xf), .i_code_in(pins),
    .o_low_nibble_latch(lo), .o_middle_nibble_latch(mi), .o_high_nibble_latch(hi), .o_output_code_latch(out));
  // 25 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // request goes up at a falling edge and drops one cycle later
  task automatic launch(input logic [11:0] c, input logic [1:0] m, input logic t, input logic d);
    i_code = c;
    i_mode = m;
    i_twos = t;
    i_double = d;
    i_req = 1'b1;
    @(negedge i_clk);
    i_req = 1'b0;
  endtask
  // bounded wait; ends in the done cycle so the next launch is back to back
  task automatic wait_done();
    int k;
    for (k = 0; k < 200 && o_done !== 1'b1; k++) begin
      @(negedge i_clk);
    end
    if (o_done !== 1'b1) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic idle();
    chk({6'h00, o_busy, sel_n, en_xf, en_hi, en_mi, en_lo}, 12'h01F);
    chk(pins, 12'h000);
  endtask
  // every hookup, boundary codes, both codings
  task automatic t_codes();
    int m, j;
    for (m = 0; m < 4; m++) begin
      for (j = 0; j < 8; j++) begin
        launch(codes[j % 4], m[1:0], j[2], 1'b0);
        wait_done();
        chk(out, codes[j % 4] ^ {j[2], 11'h000});
        chk({hi, mi, lo}, codes[j % 4] ^ {j[2], 11'h000});
      end
    end
    $display("t_codes done");
  endtask
  // output must hold the old code while the first rank fills
  task automatic t_double();
    int m;
    for (m = 0; m < 2; m++) begin
      launch(12'h3C5, 2'h0, 1'b0, 1'b0);
      wait_done();
      launch(12'hA69, m ? 2'h3 : 2'h0, 1'b0, m == 0);
      repeat (5) @(negedge i_clk);
      chk(out, 12'h3C5);
      chk({8'h00, lo}, 12'h009);
      wait_done();
      chk(out, 12'hA69);
    end
    $display("t_double done");
  endtask
  // a request while busy is dropped
  task automatic t_busy();
    launch(12'h123, 2'h1, 1'b1, 1'b0);
    repeat (3) @(negedge i_clk);
    launch(12'hEEE, 2'h0, 1'b0, 1'b0);
    wait_done();
    chk(out, 12'h923);
    idle();
    $display("t_busy done");
  endtask
  initial begin
    n_errors = 0;
    n_checks = 0;
    i_rst = 1'b1;
    i_req = 1'b0;
    i_code = 12'h000;
    i_mode = 2'h0;
    i_twos = 1'b0;
    i_double = 1'b0;
    repeat (16) @(negedge i_clk);
    i_rst = 1'b0;
    idle();
    t_codes();
    t_double();
    t_busy();
    close_out();
  end
endmodule
`default_nettype wire
